// >>> core/ncih_buf.sv
// Two-entry skid buffer for read data
`timescale 1ns/1ps
`default_nettype none
module ncih_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   reset_n,
    // Fill side
    ncih_buf_if.snk     fill,
    // Drain side
    output logic        out_valid,
    output logic [7:0]  out_data,
    input  wire logic   out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [1:0]                  cnt;
        logic                        rd;
        logic                        wr;
    } ncih_buf_st_t;

    ncih_buf_st_t s_q;
    ncih_buf_st_t s_d;
    logic         push;
    logic         pop;

    assign fill.ready = (s_q.cnt != 2'(DEPTH));
    assign push       = fill.valid && fill.ready;
    assign pop        = out_ready && (s_q.cnt != 2'h0);
    assign out_valid  = (s_q.cnt != 2'h0);
    assign out_data   = s_q.mem[s_q.rd];

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = fill.data;
            s_d.wr = ~s_q.wr;
        end
        if (pop) begin
            s_d.rd = ~s_q.rd;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    chk_buf_no_over: assert property (@(posedge clk) disable iff (!reset_n)
        s_q.cnt <= 2'(DEPTH)) else $error("buffer count over depth");
endmodule : ncih_buf
`default_nettype wire

// >>> core/ncih_buf_if.sv
// Valid/ready link between controller core and data buffer
`timescale 1ns/1ps
`default_nettype none
interface ncih_buf_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ncih_buf_if
`default_nettype wire

// >>> core/ncih_host.sv
// Host controller driving the NAND strobes and byte lines and watching the busy pin
`timescale 1ns/1ps
`default_nettype none
module ncih_host
    import ncih_pkg::*;
#(
    parameter int BUSY_WAIT = ncih_pkg::BUSY_WAIT_CYC
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // User command port
    input  wire logic                      cmd_valid,
    input  wire logic [2:0]                cmd_op,
    input  wire logic [ncih_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [5:0]                cmd_len,
    input  wire logic                      protect_n,
    output logic                           cmd_ready,
    output logic                           cmd_done,
    output logic                           cmd_timeout,
    // Program data in
    input  wire logic                      wr_valid,
    input  wire logic [7:0]                wr_data,
    output logic                           wr_ready,
    // Read data out
    output logic                           rd_valid,
    output logic [7:0]                     rd_data,
    input  wire logic                      rd_ready,
    // Device pins
    output logic                           cmd_latch,
    output logic                           addr_latch,
    output logic                           chip_sel_n,
    output logic                           write_strobe_n,
    output logic                           output_strobe_n,
    output logic                           write_prot_n,
    output logic [7:0]                     shared_byte_lines_o,
    output logic                           shared_byte_lines_oe,
    input  wire logic [7:0]                shared_byte_lines_i,
    input  wire logic                      ready_busy_n
);
    import ncih_pkg::*;

    typedef enum logic [6:0] {
        ST_PWRUP = 7'h01,
        ST_IDLE  = 7'h02,
        ST_CMD   = 7'h04,
        ST_ADDR  = 7'h08,
        ST_DATA  = 7'h10,
        ST_BUSY  = 7'h20,
        ST_READ  = 7'h40
    } ncih_state_t;

    typedef struct packed {
        ncih_state_t          st;
        logic [TMR_W-1:0]     tmr;
        logic [1:0]           ph;
        logic [7:0]           cmd2;
        logic [2:0]           op;
        logic [ADDR_W-1:0]    addr;
        logic [1:0]           acnt;
        logic [1:0]           anum;
        logic [5:0]           left;
        logic                 second;
        logic                 seen_busy;
        logic                 ready;
        logic                 done;
        logic                 tout;
        logic                 wready;
        logic                 cle;
        logic                 ale;
        logic                 ce_n;
        logic                 we_n;
        logic                 re_n;
        logic                 wp_n;
        logic [7:0]           dout;
        logic                 oe;
        logic                 bvalid;
        logic [7:0]           bdata;
    } ncih_st_t;

    ncih_st_t    s_q;
    ncih_st_t    s_d;
    logic [1:0]  rb_sync_q;
    logic [15:0] io_sync_q;
    logic        rb_ok;
    ncih_buf_if  bif();

    // Pin inputs pass two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rb_sync_q <= 2'h3;
            io_sync_q <= 16'h0000;
        end else begin
            rb_sync_q <= {rb_sync_q[0], ready_busy_n};
            io_sync_q <= {io_sync_q[7:0], shared_byte_lines_i};
        end
    end
    assign rb_ok = rb_sync_q[1];

    assign bif.valid = s_q.bvalid;
    assign bif.data  = s_q.bdata;

    ncih_buf #(.WIDTH(8), .DEPTH(2)) u_buf (
        .clk       (clk),
        .reset_n   (reset_n),
        .fill      (bif),
        .out_valid (rd_valid),
        .out_data  (rd_data),
        .out_ready (rd_ready)
    );

    always_comb begin
        s_d        = s_q;
        s_d.done   = 1'b0;
        s_d.bvalid = 1'b0;
        s_d.wready = 1'b0;
        s_d.wp_n   = protect_n;
        s_d.tmr    = s_q.tmr + TMR_W'(1);
        unique case (s_q.st)
            ST_PWRUP: begin
                if (s_q.tmr >= TMR_W'(POWERUP_CYC)) begin
                    s_d.st    = ST_IDLE;
                    s_d.ready = 1'b1;
                end
            end
            ST_IDLE: begin
                s_d.ce_n = 1'b1;
                if (cmd_valid && s_q.ready) begin
                    s_d.ready  = 1'b0;
                    s_d.tout   = 1'b0;
                    s_d.op     = cmd_op;
                    s_d.addr   = cmd_addr;
                    s_d.left   = (cmd_len > 6'(FRAME_BYTES)) ? 6'(FRAME_BYTES) : cmd_len;
                    s_d.second = 1'b0;
                    s_d.acnt   = 2'h0;
                    s_d.ce_n   = 1'b0;
                    s_d.st     = ST_CMD;
                    s_d.tmr    = '0;
                    s_d.ph     = 2'h0;
                    unique case (cmd_op)
                        OP_READ:   begin s_d.dout = CMD_READ;      s_d.anum = 2'h3; end
                        OP_PROG:   begin s_d.dout = CMD_PROG_SET;  s_d.anum = 2'h3; end
                        OP_ERASE:  begin s_d.dout = CMD_ERASE_SET; s_d.anum = 2'h2; end
                        OP_STATUS: begin s_d.dout = CMD_STATUS;    s_d.anum = 2'h0; end
                        OP_IDENT:  begin s_d.dout = CMD_IDENT;     s_d.anum = 2'h1; end
                        default:   begin s_d.dout = CMD_RESET;     s_d.anum = 2'h0; end
                    endcase
                    if (cmd_op == OP_ERASE) begin
                        s_d.addr = {cmd_addr[ADDR_W-1:8], 8'h00} >> 8;
                    end
                end
            end
            // Each strobe cycle: set lines, drop write strobe, raise it
            ST_CMD, ST_ADDR, ST_DATA: begin
                s_d.cle = (s_q.st == ST_CMD);
                s_d.ale = (s_q.st == ST_ADDR);
                s_d.oe  = 1'b1;
                if (s_q.tmr >= TMR_W'(PHASE_CYC)) begin
                    s_d.tmr = '0;
                    s_d.ph  = s_q.ph + 2'h1;
                    if (s_q.ph == 2'h0) begin
                        s_d.we_n = 1'b0;
                    end else if (s_q.ph == 2'h1) begin
                        s_d.we_n = 1'b1;
                    end else begin
                        s_d.ph = 2'h0;
                        if (s_q.st == ST_CMD && !s_q.second && s_q.anum != 2'h0) begin
                            s_d.st   = ST_ADDR;
                            s_d.dout = s_q.addr[7:0];
                        end else if (s_q.st == ST_ADDR
                                     && s_q.acnt + 2'h1 != s_q.anum) begin
                            s_d.acnt = s_q.acnt + 2'h1;
                            s_d.addr = s_q.addr >> 8;
                            s_d.dout = s_d.addr[7:0];
                        end else if (s_q.st == ST_ADDR && s_q.op == OP_PROG
                                     && s_q.left != 6'h00) begin
                            s_d.st = ST_DATA;
                            s_d.oe = 1'b0;
                        end else if (s_q.st == ST_DATA && s_q.left != 6'h00) begin
                            s_d.oe = 1'b0;
                        end else if (!s_q.second && (s_q.op == OP_PROG
                                     || s_q.op == OP_ERASE)) begin
                            s_d.st     = ST_CMD;
                            s_d.second = 1'b1;
                            s_d.dout   = (s_q.op == OP_PROG) ? CMD_PROG_GO : CMD_ERASE_GO;
                        end else begin
                            s_d.st        = ST_BUSY;
                            s_d.seen_busy = 1'b0;
                            s_d.oe        = 1'b0;
                            s_d.cle       = 1'b0;
                            s_d.ale       = 1'b0;
                        end
                    end
                end
                // Hold in phase 0 of data until a byte is offered
                if (s_q.st == ST_DATA && !s_q.oe && s_q.ph == 2'h0) begin
                    s_d.tmr = '0;
                    if (wr_valid && s_q.left != 6'h00) begin
                        s_d.dout   = wr_data;
                        s_d.oe     = 1'b1;
                        s_d.left   = s_q.left - 6'h01;
                        s_d.wready = 1'b1;
                    end else if (s_q.left == 6'h00) begin
                        s_d.oe = 1'b1;
                    end else begin
                        // No byte offered: keep lines released, no strobe
                        s_d.oe = 1'b0;
                    end
                end
            end
            ST_BUSY: begin
                // Status and identifier reads need no busy wait
                if (s_q.op == OP_STATUS || s_q.op == OP_IDENT) begin
                    s_d.left = 6'h01 + 6'(s_q.op == OP_IDENT);
                    s_d.st   = ST_READ;
                    s_d.tmr  = '0;
                    s_d.ph   = 2'h0;
                end else begin
                    if (!rb_ok) begin
                        s_d.seen_busy = 1'b1;
                    end
                    // Select may rise while program or erase runs
                    if (s_q.op != OP_READ) begin
                        s_d.ce_n = 1'b1;
                    end
                    if (rb_ok && (s_q.seen_busy || s_q.tmr >= TMR_W'(BUSY_SEEN_CYC))
                        && s_q.tmr >= TMR_W'(BUSY_SEEN_CYC)) begin
                        s_d.tmr = '0;
                        s_d.ph  = 2'h0;
                        if (s_q.op == OP_READ && s_q.left != 6'h00) begin
                            s_d.st = ST_READ;
                        end else begin
                            s_d.st = ST_IDLE;
                            s_d.done  = 1'b1;
                            s_d.ready = 1'b1;
                        end
                    end else if (s_q.tmr >= TMR_W'(BUSY_WAIT)
                                 || (s_q.op == OP_READ
                                     && s_q.tmr >= TMR_W'(READ_BUSY_CYC))) begin
                        s_d.st    = ST_IDLE;
                        s_d.tout  = 1'b1;
                        s_d.done  = 1'b1;
                        s_d.ready = 1'b1;
                    end
                end
            end
            ST_READ: begin
                s_d.ce_n = 1'b0;
                // Buffer full stalls the next output strobe
                if (s_q.tmr >= TMR_W'(PHASE_CYC) && (bif.ready || s_q.ph != 2'h0)) begin
                    s_d.tmr = '0;
                    s_d.ph  = s_q.ph + 2'h1;
                    if (s_q.ph == 2'h0) begin
                        s_d.re_n = 1'b0;
                    end else if (s_q.ph == 2'h2) begin
                        s_d.bvalid = 1'b1;
                        s_d.bdata  = io_sync_q[15:8];
                        s_d.re_n   = 1'b1;
                        s_d.ph     = 2'h0;
                        s_d.left   = s_q.left - 6'h01;
                        if (s_q.left == 6'h01) begin
                            s_d.st    = ST_IDLE;
                            s_d.ce_n  = 1'b1;
                            s_d.done  = 1'b1;
                            s_d.ready = 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q      <= '0;
            s_q.st   <= ST_PWRUP;
            s_q.ce_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.re_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_ready            = s_q.ready;
    assign cmd_done             = s_q.done;
    assign cmd_timeout          = s_q.tout;
    assign wr_ready             = s_q.wready;
    assign cmd_latch            = s_q.cle;
    assign addr_latch           = s_q.ale;
    assign chip_sel_n           = s_q.ce_n;
    assign write_strobe_n       = s_q.we_n;
    assign output_strobe_n      = s_q.re_n;
    assign write_prot_n         = s_q.wp_n;
    assign shared_byte_lines_o  = s_q.dout;
    // Enable low while driving
    assign shared_byte_lines_oe = ~s_q.oe;

    sequence s_we_fall;
        $fell(s_q.we_n);
    endsequence

    chk_no_both_latch: assert property (@(posedge clk) disable iff (!reset_n)
        !(s_q.cle && s_q.ale)) else $error("both latch strobes high");
    chk_cmd_sel_low: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(s_q.we_n) && s_q.cle |-> !s_q.ce_n) else $error("command without select");
    chk_we_width: assert property (@(posedge clk) disable iff (!reset_n)
        s_we_fall |=> !s_q.we_n [*4]) else $error("write strobe pulse too short");
    chk_read_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
        !s_q.re_n |-> !s_q.oe) else $error("host drives during output strobe");
    chk_pwrup_wait: assert property (@(posedge clk) disable iff (!reset_n)
        s_q.st == ST_PWRUP |-> s_q.we_n && s_q.ready == 1'b0) else $error("early command");
    chk_busy_cmd: assert property (@(posedge clk) disable iff (!reset_n)
        s_q.st == ST_BUSY |-> s_q.we_n) else $error("strobe while busy");
    chk_erase_two: assert property (@(posedge clk) disable iff (!reset_n)
        s_q.op == OP_ERASE && s_q.st == ST_ADDR |-> s_q.acnt < 2'h2)
        else $error("erase extra address");
    // First edge after reset still shows the reset value of the flop
    chk_prot_follow: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> s_q.wp_n == $past(protect_n)) else $error("protect not followed");
    chk_frame_max: assert property (@(posedge clk) disable iff (!reset_n)
        s_q.left <= 6'(FRAME_BYTES)) else $error("frame overrun");
endmodule : ncih_host
`default_nettype wire

// >>> core/ncih_pkg.sv
// Package for the NAND command interface host controller
package ncih_pkg;
    // Command codes
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_RESET     = 8'hFF;
    localparam logic [7:0] CMD_PROG_SET  = 8'h80;
    localparam logic [7:0] CMD_PROG_GO   = 8'h10;
    localparam logic [7:0] CMD_ERASE_SET = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_IDENT     = 8'h90;
    // User operation codes
    localparam logic [2:0] OP_READ   = 3'h0;
    localparam logic [2:0] OP_PROG   = 3'h1;
    localparam logic [2:0] OP_ERASE  = 3'h2;
    localparam logic [2:0] OP_STATUS = 3'h3;
    localparam logic [2:0] OP_IDENT  = 3'h4;
    localparam logic [2:0] OP_RESET  = 3'h5;
    // Geometry
    localparam int ADDR_W      = 19;
    localparam int FRAME_BYTES = 32;
    localparam int COL_W       = 5;
    localparam int BLOCK_LSB   = 12;
    // Timing
    localparam int CLK_MHZ        = 40;
    localparam int POWERUP_NS     = 1000;
    localparam int POWERUP_CYC    = (POWERUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PHASE_NS       = 100;
    localparam int PHASE_CYC      = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_BUSY_US   = 15;
    localparam int READ_BUSY_CYC  = READ_BUSY_US * CLK_MHZ;
    localparam int BUSY_WAIT_US   = 20000;
    localparam int BUSY_WAIT_CYC  = BUSY_WAIT_US * CLK_MHZ;
    localparam int BUSY_SEEN_NS   = 200;
    localparam int BUSY_SEEN_CYC  = (BUSY_SEEN_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W          = 20;
endpackage : ncih_pkg

// >>> dv/ncih_nand_model.sv
// Behavioural model of the flash device behind the host controller
`timescale 1ns/1ps
`default_nettype none
module ncih_nand_model #(
    parameter logic [7:0] STAT  = 8'hC0,
    parameter logic [7:0] ID0   = 8'h3C, // Arbitrary value
    parameter logic [7:0] ID1   = 8'hC3, // Arbitrary value
    parameter int         RD_NS = 2000,
    parameter int         PG_NS = 5000,
    parameter int         ER_NS = 10000
) (
    // Supply and strobes
    input  wire logic       power_ok,
    input  wire logic       cmd_latch,
    input  wire logic       addr_latch,
    input  wire logic       chip_sel_n,
    input  wire logic       write_strobe_n,
    input  wire logic       output_strobe_n,
    input  wire logic       write_prot_n,
    // Byte lines and busy
    input  wire logic [7:0] bus_in,
    output logic      [7:0] bus_out,
    output logic            bus_drv,
    output logic            ready_busy_n,
    // Host breaches seen
    output int              viol
);
    logic [7:0] mem [int];
    logic [7:0] dreg [0:31];
    logic [7:0] cmd;
    logic [7:0] ab [0:2];
    logic [4:0] col;
    logic       busy = 1'b0;
    int         na = 0, mode = 0, idx = 0, gen = 0;
    realtime    t_on = 0;
    wire [18:0] fa = {ab[2][2:0], ab[1], ab[0]};
    wire [18:0] ba = {ab[1][2:0], ab[0][7:4], 12'h000};

    function automatic logic [7:0] rd(input logic [18:0] x);
        return mem.exists(x) ? mem[x] : 8'hFF;
    endfunction : rd
    // Generation count lets reset cut a pending busy short
    task automatic go_busy(input int ns);
        gen++;
        busy = 1'b1;
        fork
            begin
                automatic int g = gen;
                #(ns);
                if (g == gen) busy = 1'b0;
            end
        join_none
    endtask : go_busy

    assign ready_busy_n = !busy;
    assign bus_drv = !output_strobe_n && !chip_sel_n && !busy && mode != 0;
    initial viol = 0;
    always @(posedge power_ok) t_on = $realtime;
    always @(posedge write_strobe_n) begin
        if (cmd_latch && !chip_sel_n) begin
            if (busy && bus_in != 8'hFF && bus_in != 8'h70) viol++;
            if (!(bus_in inside {8'h00, 8'hFF, 8'h80, 8'h10, 8'h60, 8'hD0, 8'h70, 8'h90}))
                viol++;
            if ($realtime - t_on < 1000.0) viol++;
            case (bus_in)
                8'hFF: begin gen++; busy = 1'b0; mode = 0; end
                8'h70: mode = 3;
                8'h10: begin
                    if (cmd != 8'h80 || na != 3) viol++;
                    if (write_prot_n) for (int i = 0; i < 32; i++)
                        mem[{fa[18:5], 5'h00} + i] = rd({fa[18:5], 5'h00} + i) & dreg[i];
                    mode = 0;
                    go_busy(PG_NS);
                end
                8'hD0: begin
                    if (cmd != 8'h60 || na != 2) viol++;
                    if (write_prot_n) for (int i = 0; i < 4096; i++) mem.delete(ba + i);
                    mode = 0;
                    go_busy(ER_NS);
                end
                default: begin
                    cmd = bus_in;
                    na = 0;
                    idx = 0;
                    mode = (bus_in == 8'h90) ? 4 : 0;
                    if (bus_in == 8'h80) for (int i = 0; i < 32; i++) dreg[i] = 8'hFF;
                end
            endcase
        end else if (addr_latch) begin
            if (na < (cmd == 8'h60 ? 2 : cmd == 8'h90 ? 1 : 3)) begin
                ab[na] = bus_in;
                na++;
                col = ab[0][4:0];
                if (na == 3 && cmd == 8'h00) begin mode = 1; go_busy(RD_NS); end
                if (na == 3 && cmd == 8'h80) mode = 2;
            end
        end else if (!chip_sel_n && mode == 2) begin
            dreg[col] = bus_in;
            if (col != 5'd31) col++;
        end
    end
    always @(negedge output_strobe_n) if (!busy) begin
        case (mode)
            1: begin bus_out = rd({fa[18:5], col}); col++; end
            3: bus_out = STAT;
            4: begin bus_out = (idx == 0) ? ID0 : ID1; idx++; end
            default: ;
        endcase
    end
    // Only a read in flight is dropped; program and erase run on
    always @(posedge chip_sel_n) if (mode == 1 && busy) begin gen++; busy = 1'b0; mode = 0; end
endmodule : ncih_nand_model
`default_nettype wire

// >>> dv/tb_nand_command_interface.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_nand_command_interface;
    import ncih_pkg::*;
    localparam logic [7:0] STAT = 8'hC0, ID0 = 8'h3C, ID1 = 8'hC3; // Arbitrary values
    logic clk = 0, reset_n = 0, cmd_valid = 0, protect_n = 1, wr_valid = 0, rd_ready = 0, hold = 0;
    logic [2:0] cmd_op = 0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [5:0] cmd_len = 0;
    logic [7:0] wr_data = 0, shared_byte_lines_i = 0, lfsr = 8'd31, rs = 8'd31, mon_e;
    wire logic cmd_ready, cmd_done, cmd_timeout, wr_ready, rd_valid, cmd_latch, addr_latch;
    wire logic chip_sel_n, write_strobe_n, output_strobe_n, write_prot_n, shared_byte_lines_oe;
    wire logic ready_busy_n, bus_drv;
    wire logic [7:0] rd_data, shared_byte_lines_o, bus_out;
    int n_mismatch = 0, comparisons = 0, cyc = 0, viol;
    logic [7:0] expq [$];
    logic [7:0] sh [int];

    ncih_host #(.BUSY_WAIT(2000)) dut (.clk, .reset_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_len,
        .protect_n, .cmd_ready, .cmd_done, .cmd_timeout, .wr_valid, .wr_data, .wr_ready, .rd_valid,
        .rd_data, .rd_ready, .cmd_latch, .addr_latch, .chip_sel_n, .write_strobe_n, .output_strobe_n,
        .write_prot_n, .shared_byte_lines_o, .shared_byte_lines_oe, .shared_byte_lines_i, .ready_busy_n);
    ncih_nand_model #(.STAT(STAT), .ID0(ID0), .ID1(ID1)) dev (.power_ok(reset_n), .cmd_latch,
        .addr_latch, .chip_sel_n, .write_strobe_n, .output_strobe_n, .write_prot_n,
        .bus_in(shared_byte_lines_i), .bus_out, .bus_drv, .ready_busy_n, .viol);

    // No pull on the byte lines, so a released line shows the inverse of its last level
    always @(shared_byte_lines_o, shared_byte_lines_oe, bus_out, bus_drv)
        shared_byte_lines_i = (shared_byte_lines_oe === 1'b0) ? shared_byte_lines_o
                            : bus_drv ? bus_out : ~shared_byte_lines_i;
    always #12.5 clk = ~clk;

    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt
    function automatic logic [7:0] ex(input logic [18:0] x);
        return sh.exists(x) ? sh[x] : 8'hFF;
    endfunction : ex
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        lfsr <= nxt(lfsr);
        rd_ready <= !hold && (lfsr[1:0] != 2'b00);
        cyc <= cyc + 1;
        if (cyc > 60000) begin n_mismatch++; finish_test(); end
    end
    always @(posedge clk) if (reset_n) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            mon_e = (expq.size() != 0) ? expq.pop_front() : ~rd_data;
            `CHK("rd_data", mon_e, rd_data)
        end
        if (shared_byte_lines_oe === 1'b0 && bus_drv) `CHK("bus_fight", 1'b0, 1'b1)
    end

    task automatic op(input logic [2:0] o, input logic [18:0] a, input int n);
        int k;
        k = 0;
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_addr <= a;
        cmd_len <= n[5:0];
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do begin @(posedge clk); k++; end while (cmd_done !== 1'b1 && k < 20000);
        `CHK("cmd_done", 1'b1, cmd_done)
        @(posedge clk);
        `CHK("cmd_timeout", 1'b0, cmd_timeout)
    endtask : op
    task automatic rd(input logic [18:0] a, input int n);
        for (int i = 0; i < n; i++) expq.push_back(ex(a + i));
        op(OP_READ, a, n);
    endtask : rd
    task automatic pg(input logic [18:0] a, input bit upd);
        logic [7:0] d [0:31];
        for (int i = 0; i < 32; i++) begin rs = nxt(rs); d[i] = rs; end
        fork
            begin
                for (int i = 0; i < 32; i++) begin
                    // Random producer stall makes the controller wait for a byte
                    if (lfsr[2]) begin wr_valid <= 1'b0; repeat (20) @(posedge clk); end
                    wr_valid <= 1'b1;
                    wr_data <= d[i];
                    do @(posedge clk); while (wr_ready !== 1'b1);
                end
                wr_valid <= 1'b0;
            end
            op(OP_PROG, a, 32);
        join
        if (upd) for (int i = 0; i < 32; i++) sh[a + i] = ex(a + i) & d[i];
    endtask : pg
    task automatic er(input logic [18:0] a);
        op(OP_ERASE, a, 0);
        for (int i = 0; i < 4096; i++) sh.delete({a[18:12], 12'h000} + i);
    endtask : er

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        er(19'h03000);
        pg(19'h03040, 1'b1);
        hold <= 1'b1;
        fork // Receiver stalls for 120 cycles, ending before the first read byte reaches the buffer
            begin repeat (120) @(posedge clk); hold <= 1'b0; end
            rd(19'h03040, 32);
        join
        rd(19'h0305C, 4);
        pg(19'h7FFE0, 1'b1);
        rd(19'h7FFE0, 32);
        protect_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("write_prot_n", 1'b0, write_prot_n)
        pg(19'h03060, 1'b0);
        rd(19'h03060, 8);
        protect_n <= 1'b1;
        expq.push_back(STAT);
        op(OP_STATUS, 19'h0, 1);
        expq.push_back(ID0);
        expq.push_back(ID1);
        op(OP_IDENT, 19'h0, 2);
        op(OP_RESET, 19'h0, 0);
        er(19'h03000);
        rd(19'h03040, 8);
        // Let the receiver drain what the buffer still holds
        for (int i = 0; i < 64 && expq.size() != 0; i++) @(posedge clk);
        `CHK("viol", 0, viol)
        `CHK("queue", 0, expq.size())
        finish_test();
    end
endmodule : tb_nand_command_interface
`default_nettype wire
